/* scm_pkg.sv */
package scm_pkg;
   // ==========================================================
   // clock and link framing
   localparam int CLK_HZ     = 125_000_000;
   localparam int CLK_MHZ    = CLK_HZ / 1_000_000;
   localparam int FRAME_BITS = 16;

   // ==========================================================
   // command word layout and reset values
   localparam int         CMD_IRQ_EN_LSB = 0;
   localparam int         CMD_TYPE_A_BIT = 8;
   localparam int         CMD_TYPE_B_BIT = 9;
   localparam int         CMD_DIRECT_BIT = 10;
   localparam logic [7:0] IRQ_EN_RESET   = 8'hFF;
   localparam logic       TYPE_RESET     = 1'b0;
   localparam logic       DIRECT_RESET   = 1'b0;

   // ==========================================================
   // status word layout
   localparam int ST_SW_LSB  = 0;
   localparam int ST_HOT_BIT = 8;
   localparam int ST_WD_BIT  = 9;
   localparam int ST_UV_BIT  = 10;

   // ==========================================================
   // supervisor timing
   localparam int T_RST_US      = 21000;
   localparam int RST_PULSE_CYC = T_RST_US * CLK_MHZ;
   localparam int WD1_RATIO     = 4;
   localparam int WD2_RATIO     = 8;
   localparam int T_DEB_US      = 5900;
   localparam int DEB_SAMPLES   = 4;
   localparam int DEB_TICK_CYC  =
      (T_DEB_US * CLK_MHZ + DEB_SAMPLES - 1) / DEB_SAMPLES;

   // ==========================================================
   // host serial clock: at most 5 MHz, half period rounded up
   localparam int SPI_F_MAX_KHZ = 5000;
   localparam int SCLK_HALF_CYC =
      (CLK_HZ / 1000 + 2 * SPI_F_MAX_KHZ - 1) / (2 * SPI_F_MAX_KHZ);

   // ==========================================================
   // host register map (byte offsets) and fields
   localparam logic [7:0] REG_TX        = 8'h00;
   localparam logic [7:0] REG_RX        = 8'h04;
   localparam logic [7:0] REG_STAT      = 8'h08;
   localparam logic [7:0] REG_PINS      = 8'h0C;
   localparam int         STAT_BUSY_BIT = 0;
   localparam int         STAT_INT_BIT  = 1;
   localparam int         STAT_RST_BIT  = 2;
   localparam int         PINS_KICK_BIT = 0;
   localparam int         PINS_OFF_BIT  = 1;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

/* scm_link_if.sv */
`timescale 1ns/1ps
interface scm_link_if;
   // host driven pins
   logic sclk;
   logic cs_n;
   logic mosi;
   logic wdog_kick;
   logic ldo_off_n;
   // device drives and enables
   logic miso_o;
   logic miso_oe;
   logic int_oe;
   logic rst_oe;
   // resolved wire levels
   logic miso;
   logic int_n;
   logic rst_n;

   // ==========================================================
   // wire resolution: released data reads low, open drains pull up
   assign miso  = miso_oe & miso_o;
   assign int_n = ~int_oe;
   assign rst_n = ~rst_oe;

   modport dev (input sclk, cs_n, mosi, wdog_kick, ldo_off_n, int_n,
                output miso_o, miso_oe, int_oe, rst_oe);
   modport host (output sclk, cs_n, mosi, wdog_kick, ldo_off_n,
                 input miso, int_n, rst_n);
endinterface // scm_link_if

/* sync2.sv */
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         i_sys_clk,
   input  wire logic         i_rstn,
   // levels from outside the domain
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } sync_t;

   sync_t s;
   sync_t next_s;

   if (W < 1) begin : g_bad_w
      $error("sync2 width must be at least one");
   end

   // ==========================================================
   // first stage feeds only the second
   always_comb begin
      next_s      = s;
      next_s.meta = i_async;
      next_s.sync = s.meta;
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_sync = s.sync;
endmodule // sync2

/* scm_device.sv */
`timescale 1ns/1ps
module scm_device import scm_pkg::*; #(
   parameter int RST_CYCLES = RST_PULSE_CYC,
   parameter int DEB_TICK   = DEB_TICK_CYC
) (
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rstn,
   // link to the host
   scm_link_if.dev         link,
   // switch and analog monitor levels
   input  wire logic [7:0] i_switch_ch,
   input  wire logic       i_uv_below,
   input  wire logic       i_thermal_hot,
   // regulator and mode pins
   input  wire logic       i_shutdown_n,
   input  wire logic       i_ldo_on_n,
   output logic            o_ldo_en,
   // pass-through and open-drain flag
   output logic            o_pass_out0,
   output logic            o_pass_out1,
   output logic            o_thermal_warn_n_oe
);
   localparam int WD1 = WD1_RATIO * RST_CYCLES;
   localparam int WD2 = WD2_RATIO * RST_CYCLES;
   localparam int WW  = $clog2(WD2 + 1);
   localparam int DW  = $clog2(DEB_TICK + 1);
   localparam logic [WW-1:0] WD1_LAST = WW'(WD1 - 1);
   localparam logic [WW-1:0] WD2_LAST = WW'(WD2 - 1);
   localparam logic [WW-1:0] RST_LAST = WW'(RST_CYCLES - 1);
   localparam logic [DW-1:0] DEB_LAST = DW'(DEB_TICK - 1);
   localparam logic [1:0]    SMP_LAST = 2'(DEB_SAMPLES - 1);
   localparam logic [4:0]    FRAME_N  = 5'(FRAME_BITS);

   if (RST_CYCLES < 1 || DEB_TICK < 1 || DEB_SAMPLES > 4) begin : g_bad
      $error("scm_device timing parameters out of range");
   end

   typedef struct packed {
      logic             sclk_d;
      logic             cs_d;
      logic             kick_d;
      logic [15:0]      rx;
      logic [15:0]      tx;
      logic [4:0]       bitcnt;
      logic             miso;
      logic             miso_oe;
      logic [7:0]       irq_en;
      logic             type_a;
      logic             type_b;
      logic             direct_sel;
      logic [DW-1:0]    deb_div;
      logic [7:0][1:0]  deb_cnt;
      logic [7:0]       sw_state;
      logic             int_sw;
      logic             int_wd;
      logic [WW-1:0]    wd_cnt;
      logic             rst_phase;
      logic             int_oe;
      logic             rst_oe;
      logic             hot_oe;
      logic             ldo_en;
      logic             pass0;
      logic             pass1;
   } dev_state_t;

   localparam dev_state_t ST_RESET = '{
      cs_d: 1'b1, irq_en: IRQ_EN_RESET, type_a: TYPE_RESET,
      type_b: TYPE_RESET, direct_sel: DIRECT_RESET, default: '0};

   dev_state_t s;
   dev_state_t next_s;

   logic [16:0] pin_async;
   logic [16:0] pin;
   logic        sclk;
   logic        cs_on;
   logic        cs_n;
   logic        mosi;
   logic        kick;
   logic        off_n;
   logic        on_n;
   logic        sd_n;
   logic        uv;
   logic        hot;
   logic [7:0]  raw;

   // ==========================================================
   // closed level per channel; 4-7 follow their pair type
   function automatic logic [7:0] to_closed(input logic [7:0] lvl,
                                            input logic ta,
                                            input logic tb);
      logic [7:0] c;
      c = ~lvl;
      if (ta) begin
         c[5:4] = lvl[5:4];
      end
      if (tb) begin
         c[7:6] = lvl[7:6];
      end
      return c;
   endfunction

   // ==========================================================
   // every pin crosses two flops before use; select is synced active
   // high so the cleared synchroniser reads deselected after reset
   assign pin_async = {link.sclk, ~link.cs_n, link.mosi, link.wdog_kick,
                       link.ldo_off_n, i_ldo_on_n, i_shutdown_n,
                       i_uv_below, i_thermal_hot, i_switch_ch};

   sync2 #(.W(17)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_async   (pin_async),
      .o_sync    (pin)
   );

   assign {sclk, cs_on, mosi, kick, off_n, on_n, sd_n, uv, hot, raw} = pin;
   assign cs_n = ~cs_on;

   // ==========================================================
   // whole next state
   always_comb begin
      logic       rise;
      logic       fall;
      logic       cs_rise;
      logic       tick;
      logic       chg;
      logic [7:0] closed;
      logic [7:0] vis;
      rise    = sclk & ~s.sclk_d;
      fall    = ~sclk & s.sclk_d;
      cs_rise = cs_n & ~s.cs_d;
      tick    = (s.deb_div == DEB_LAST);
      chg     = 1'b0;
      closed  = to_closed(raw, s.type_a, s.type_b);
      // direct channels are hidden from status and interrupts
      vis     = {6'h3F, {2{s.direct_sel}}};
      next_s  = s;
      next_s.sclk_d = sclk;
      next_s.cs_d   = cs_n;
      next_s.kick_d = kick;

      // serial port; a frame loads a fresh status snapshot
      if (~cs_n & s.cs_d) begin
         next_s.tx     = 16'h0000;
         next_s.tx[ST_SW_LSB +: 8] = s.sw_state & vis;
         next_s.tx[ST_HOT_BIT]     = hot;
         next_s.tx[ST_WD_BIT]      = s.int_wd;
         next_s.tx[ST_UV_BIT]      = uv;
         next_s.bitcnt = 5'h00;
      end else if (!cs_n) begin
         if (rise) begin
            next_s.miso = s.tx[15];
            next_s.tx   = {s.tx[14:0], 1'b0};
         end
         if (fall) begin
            next_s.rx = {s.rx[14:0], mosi};
            if (s.bitcnt != 5'h1F) begin
               next_s.bitcnt = s.bitcnt + 5'h01;
            end
         end
      end
      next_s.miso_oe = ~cs_n;

      // partial frames never touch the command word
      if (cs_rise && s.bitcnt == FRAME_N) begin
         next_s.irq_en     = s.rx[CMD_IRQ_EN_LSB +: 8];
         next_s.type_a     = s.rx[CMD_TYPE_A_BIT];
         next_s.type_b     = s.rx[CMD_TYPE_B_BIT];
         next_s.direct_sel = s.rx[CMD_DIRECT_BIT];
      end

      // debounce: shared tick, per channel run of equal samples
      next_s.deb_div = tick ? '0 : s.deb_div + DW'(1);
      if (tick && sd_n) begin
         for (int i = 0; i < 8; i++) begin
            if (closed[i] != s.sw_state[i]) begin
               if (s.deb_cnt[i] == SMP_LAST) begin
                  next_s.sw_state[i] = closed[i];
                  next_s.deb_cnt[i]  = 2'h0;
                  if (s.irq_en[i] && vis[i]) begin
                     chg = 1'b1;
                  end
               end else begin
                  next_s.deb_cnt[i] = s.deb_cnt[i] + 2'h1;
               end
            end else begin
               next_s.deb_cnt[i] = 2'h0;
            end
         end
      end
      // a new change beats the release by a transfer
      next_s.int_sw = chg | (s.int_sw & ~cs_rise);

      // watchdog; the reset pulse ignores kicks until it ends
      if (s.rst_phase) begin
         if (s.wd_cnt == RST_LAST) begin
            next_s.rst_phase = 1'b0;
            next_s.wd_cnt    = '0;
         end else begin
            next_s.wd_cnt = s.wd_cnt + WW'(1);
         end
      end else if (kick != s.kick_d) begin
         next_s.wd_cnt = '0;
         next_s.int_wd = 1'b0;
      end else if (s.wd_cnt == WD2_LAST) begin
         next_s.rst_phase = 1'b1;
         next_s.int_wd    = 1'b0;
         next_s.wd_cnt    = '0;
      end else begin
         next_s.wd_cnt = s.wd_cnt + WW'(1);
         if (s.wd_cnt == WD1_LAST) begin
            next_s.int_wd = 1'b1;
         end
      end

      // open-drain enables from next values so pins are flops
      next_s.int_oe = next_s.int_sw | next_s.int_wd;
      next_s.rst_oe = uv | next_s.rst_phase;
      next_s.hot_oe = hot;

      // regulator latch: on_n sets, off_n low releases
      next_s.ldo_en = sd_n & (~on_n | (s.ldo_en & off_n));

      // direct copies are plain levels, low while direct_sel is set
      next_s.pass0 = ~s.direct_sel & raw[0];
      next_s.pass1 = ~s.direct_sel & raw[1];
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s <= ST_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // outputs straight from state
   assign link.miso_o         = s.miso;
   assign link.miso_oe        = s.miso_oe;
   assign link.int_oe         = s.int_oe;
   assign link.rst_oe         = s.rst_oe;
   assign o_ldo_en            = s.ldo_en;
   assign o_pass_out0         = s.pass0;
   assign o_pass_out1         = s.pass1;
   assign o_thermal_warn_n_oe = s.hot_oe;
endmodule // scm_device

/* scm_host.sv */
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module scm_host import scm_pkg::*; #(
   parameter int HALF_CYC = SCLK_HALF_CYC
) (
   // clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   // axi4-lite write
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   // axi4-lite read
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [7:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   // link to the device
   scm_link_if.host         link
);
   localparam int HW = $clog2(HALF_CYC + 1);
   localparam logic [HW-1:0] HALF_LAST = HW'(HALF_CYC - 1);
   localparam logic [4:0]    FRAME_N   = 5'(FRAME_BITS);

   // device needs about six cycles to answer a clock edge
   if (HALF_CYC < 8) begin : g_bad
      $error("scm_host half period too short");
   end

   typedef enum logic [5:0] {
      H_IDLE = 6'b000001,
      H_LEAD = 6'b000010,
      H_HIGH = 6'b000100,
      H_LOW  = 6'b001000,
      H_LAG  = 6'b010000,
      H_GAP  = 6'b100000
   } hstate_t;

   typedef struct packed {
      hstate_t        st;
      logic [HW-1:0]  hcnt;
      logic [4:0]     bitcnt;
      logic [15:0]    txw;
      logic [15:0]    tx;
      logic [15:0]    rx;
      logic           sclk;
      logic           cs_n;
      logic           mosi;
      logic           kick;
      logic           off_n;
      logic           awready;
      logic           aw_hold;
      logic [7:0]     awaddr;
      logic           wready;
      logic           w_hold;
      logic [31:0]    wdata;
      logic [3:0]     wstrb;
      logic           bvalid;
      logic [1:0]     bresp;
      logic           arready;
      logic           rvalid;
      logic [31:0]    rdata;
      logic [1:0]     rresp;
   } host_state_t;

   localparam host_state_t ST_RESET = '{st: H_IDLE, cs_n: 1'b1,
                                        default: '0};

   host_state_t s;
   host_state_t next_s;
   logic [2:0]  pin;
   logic        miso;
   logic        int_n;
   logic        rst_n;

   // ==========================================================
   // byte-lane merge for register writes
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] stb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (stb[b]) begin
            r[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return r;
   endfunction

   sync2 #(.W(3)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_async   ({link.miso, link.int_n, link.rst_n}),
      .o_sync    (pin)
   );

   assign {miso, int_n, rst_n} = pin;

   // ==========================================================
   // frame engine, then the bus slave
   always_comb begin
      logic        tdone;
      logic [31:0] m;
      tdone  = (s.hcnt == HALF_LAST);
      m      = 32'h0000_0000;
      next_s = s;
      if (s.st != H_IDLE) begin
         next_s.hcnt = tdone ? '0 : s.hcnt + HW'(1);
      end

      // clock idles low; data moves on rise, sampled on fall
      unique case (s.st)
         H_IDLE: ;
         H_LEAD: if (tdone) begin
            next_s.st   = H_HIGH;
            next_s.sclk = 1'b1;
         end
         H_HIGH: if (tdone) begin
            next_s.st     = H_LOW;
            next_s.sclk   = 1'b0;
            next_s.rx     = {s.rx[14:0], miso};
            next_s.bitcnt = s.bitcnt + 5'h01;
         end
         H_LOW: if (tdone) begin
            if (s.bitcnt == FRAME_N) begin
               next_s.st = H_LAG;
            end else begin
               next_s.st   = H_HIGH;
               next_s.sclk = 1'b1;
               next_s.mosi = s.tx[14];
               next_s.tx   = {s.tx[14:0], 1'b0};
            end
         end
         H_LAG: if (tdone) begin
            next_s.st   = H_GAP;
            next_s.cs_n = 1'b1;
         end
         H_GAP: if (tdone) begin
            next_s.st = H_IDLE;
         end
      endcase

      // write channels taken in either order
      if (i_awvalid && s.awready) begin
         next_s.aw_hold = 1'b1;
         next_s.awaddr  = i_awaddr;
      end
      if (i_wvalid && s.wready) begin
         next_s.w_hold = 1'b1;
         next_s.wdata  = i_wdata;
         next_s.wstrb  = i_wstrb;
      end
      if (s.bvalid && i_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.aw_hold && s.w_hold && !s.bvalid) begin
         next_s.aw_hold = 1'b0;
         next_s.w_hold  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = RESP_OKAY;
         case (s.awaddr)
            REG_TX: begin
               if (s.st == H_IDLE) begin
                  m = wmerge({16'h0000, s.txw}, s.wdata, s.wstrb);
                  next_s.txw    = m[15:0];
                  next_s.tx     = m[15:0];
                  next_s.mosi   = m[15];
                  next_s.cs_n   = 1'b0;
                  next_s.bitcnt = 5'h00;
                  next_s.hcnt   = '0;
                  next_s.st     = H_LEAD;
               end else begin
                  next_s.bresp = RESP_SLVERR;
               end
            end
            REG_PINS: begin
               m = wmerge({30'h0, s.off_n, s.kick}, s.wdata, s.wstrb);
               next_s.kick  = m[PINS_KICK_BIT];
               next_s.off_n = m[PINS_OFF_BIT];
            end
            default: next_s.bresp = RESP_SLVERR;
         endcase
      end
      next_s.awready = ~next_s.aw_hold & ~next_s.bvalid;
      next_s.wready  = ~next_s.w_hold & ~next_s.bvalid;

      // read: one outstanding, answer the cycle after
      if (s.rvalid && i_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (i_arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         next_s.rdata  = 32'h0000_0000;
         case (i_araddr)
            REG_TX:   next_s.rdata[15:0] = s.txw;
            REG_RX:   next_s.rdata[15:0] = s.rx;
            REG_STAT: begin
               next_s.rdata[STAT_BUSY_BIT] = (s.st != H_IDLE);
               next_s.rdata[STAT_INT_BIT]  = int_n;
               next_s.rdata[STAT_RST_BIT]  = rst_n;
            end
            REG_PINS: begin
               next_s.rdata[PINS_KICK_BIT] = s.kick;
               next_s.rdata[PINS_OFF_BIT]  = s.off_n;
            end
            default:  next_s.rresp = RESP_SLVERR;
         endcase
      end
      next_s.arready = ~next_s.rvalid;
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s <= ST_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // outputs straight from state
   assign o_awready      = s.awready;
   assign o_wready       = s.wready;
   assign o_bvalid       = s.bvalid;
   assign o_bresp        = s.bresp;
   assign o_arready      = s.arready;
   assign o_rvalid       = s.rvalid;
   assign o_rdata        = s.rdata;
   assign o_rresp        = s.rresp;
   assign link.sclk      = s.sclk;
   assign link.cs_n      = s.cs_n;
   assign link.mosi      = s.mosi;
   assign link.wdog_kick = s.kick;
   assign link.ldo_off_n = s.off_n;
endmodule // scm_host

/* scm_properties.sv */
`timescale 1ns/1ps
module scm_properties (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // link wires
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic rst_oe
);
   // ==========================================================
   // serial clock rises counted within each frame
   typedef struct packed {logic p; logic [5:0] n;} mon_t;
   mon_t m, next_m;
   always_comb begin
      next_m = m;
      next_m.p = sclk;
      if (cs_n) next_m.n = 6'h00;
      else if (sclk && !m.p) next_m.n = m.n + 6'h01;
   end
   // registered copy
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) m <= '0;
      else m <= next_m;
   end
   // ==========================================================
   // link timing; six cycles leave room for the input sync
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   oe_idle_a: assert property (cs_n [*6] |-> !miso_oe)
      else $error("data out driven while deselected");
   oe_frame_a: assert property (!cs_n [*6] |-> miso_oe)
      else $error("data out released in frame");
   miso_hold_a: assert property (
      $fell(sclk) && !cs_n |=> $stable(miso_o) [*6])
      else $error("data out moved in low phase");
   mosi_hold_a: assert property ($fell(sclk) |-> $stable(mosi) [*2])
      else $error("data in moved at falling edge");
   sclk_framed_a: assert property (sclk |-> !cs_n)
      else $error("serial clock outside frame");
   lead_time_a: assert property ($fell(cs_n) |-> !sclk [*6])
      else $error("serial clock too soon after select");
   lag_time_a: assert property ($rose(cs_n) |-> !$past(sclk, 8))
      else $error("select rose too soon after clock");
   frame_bits_a: assert property ($rose(cs_n) |-> m.n == 6'h10)
      else $error("frame not sixteen bits");
   rst_pulse_a: assert property ($rose(rst_oe) |-> rst_oe [*8])
      else $error("reset pulse too short");
endmodule // scm_properties

/* switch_contact_monitor_supervisor_test.sv */
`timescale 1ns/1ps
module switch_contact_monitor_supervisor_test import scm_pkg::*;;
   // ==========================================================
   // bench signals
   logic        i_sys_clk, i_rstn, i_awvalid, o_awready, i_wvalid, o_wready;
   logic        o_bvalid, i_bready, i_arvalid, o_arready, o_rvalid, i_rready;
   logic [7:0]  i_awaddr, i_araddr, i_switch_ch;
   logic [31:0] i_wdata, o_rdata, v;
   logic [1:0]  o_bresp, o_rresp, rsp, pins;
   logic        i_uv_below, i_thermal_hot, i_shutdown_n, i_ldo_on_n;
   logic        o_ldo_en, o_pass_out0, o_pass_out1, o_thermal_warn_n_oe;
   int          failures = 0, samples_checked = 0, cycles = 0;
   // ==========================================================
   // both ends joined, short timing parameters
   scm_link_if scm_link_if_i();
   scm_device #(.RST_CYCLES(2000), .DEB_TICK(4)) scm_device_i (
      .i_sys_clk, .i_rstn, .link(scm_link_if_i.dev), .i_switch_ch,
      .i_uv_below, .i_thermal_hot, .i_shutdown_n, .i_ldo_on_n, .o_ldo_en,
      .o_pass_out0, .o_pass_out1, .o_thermal_warn_n_oe);
   scm_host #(.HALF_CYC(8)) scm_host_i (
      .i_sys_clk, .i_rstn, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
      .o_wready, .i_wdata, .i_wstrb(4'hF), .o_bvalid, .i_bready, .o_bresp,
      .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata,
      .o_rresp, .link(scm_link_if_i.host));
   scm_properties scm_properties_i (.i_sys_clk, .i_rstn,
      .sclk(scm_link_if_i.sclk), .cs_n(scm_link_if_i.cs_n),
      .mosi(scm_link_if_i.mosi), .miso_o(scm_link_if_i.miso_o),
      .miso_oe(scm_link_if_i.miso_oe), .rst_oe(scm_link_if_i.rst_oe));
   // clock and hang guard
   initial begin
      i_sys_clk = 1'b0;
      forever #4 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 50000) begin
         failures = failures + 1;
         close_out();
      end
   end
   // ==========================================================
   // bus and compare tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      {i_awvalid, i_wvalid, i_bready} <= 3'h7;
      i_awaddr <= a;
      i_wdata <= d;
      do begin
         @(posedge i_sys_clk);
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (!o_bvalid);
      rsp = o_bresp;
      i_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_sys_clk);
      {i_arvalid, i_rready} <= 2'h3;
      i_araddr <= a;
      do begin
         @(posedge i_sys_clk);
         if (o_arready) i_arvalid <= 1'b0;
      end while (!o_rvalid);
      v = o_rdata;
      rsp = o_rresp;
      i_rready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(v, e);
   endtask
   task automatic pin(input logic [1:0] p);
      pins = p;
      wr(REG_PINS, {30'h0, p});
   endtask
   // frame sent with a watchdog kick, then wait for idle
   task automatic frame(input logic [15:0] w);
      pin(pins ^ 2'h1);
      wr(REG_TX, {16'h0, w});
      chk({30'h0, rsp}, {30'h0, RESP_OKAY});
      do rd(REG_STAT); while (v[0] !== 1'b0);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   task automatic ldo(input logic e);
      wt(8);
      chk({31'h0, o_ldo_en}, {31'h0, e});
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ==========================================================
   // test sequence
   initial begin
      {i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
      {i_awaddr, i_araddr, i_wdata, i_uv_below, i_thermal_hot} = '0;
      {i_switch_ch, i_shutdown_n, i_ldo_on_n, pins} = 12'hFFC;
      wt(4);
      i_rstn <= 1'b1;
      wt(4);
      rc(REG_PINS, 32'h0);
      rc(8'h10, 32'h0);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      i_switch_ch <= 8'hFE;
      wt(10);
      chk({30'h0, o_pass_out1, o_pass_out0}, 32'h2);
      $display("direct path test done");
      i_switch_ch <= 8'hFF;
      i_thermal_hot <= 1'b1;
      frame(16'h04FF);
      chk({30'h0, o_pass_out1, o_pass_out0}, 32'h0);
      chk({31'h0, o_thermal_warn_n_oe}, 32'h1);
      rc(REG_RX, 32'h0100);
      i_switch_ch <= 8'hFB;
      wt(2);
      i_switch_ch <= 8'hFF;
      wt(60);
      rc(REG_STAT, 32'h6);
      i_switch_ch <= 8'hFB;
      wt(60);
      rc(REG_STAT, 32'h4);
      frame(16'h04F7);
      rc(REG_RX, 32'h0104);
      rc(REG_STAT, 32'h6);
      i_switch_ch <= 8'hF3;
      wt(60);
      rc(REG_STAT, 32'h6);
      frame(16'h05F7);
      wt(60);
      rc(REG_STAT, 32'h4);
      frame(16'h05F7);
      rc(REG_RX, 32'h013C);
      $display("switch test done");
      i_uv_below <= 1'b1;
      wt(8);
      rc(REG_STAT, 32'h2);
      i_uv_below <= 1'b0;
      i_ldo_on_n <= 1'b0;
      ldo(1'b1);
      pin(2'h2);
      i_ldo_on_n <= 1'b1;
      ldo(1'b1);
      pin(2'h0);
      ldo(1'b0);
      {i_ldo_on_n, i_shutdown_n} <= 2'h0;
      ldo(1'b0);
      {i_ldo_on_n, i_shutdown_n} <= 2'h3;
      $display("regulator test done");
      pin(2'h1);
      wt(6000);
      pin(2'h0);
      wt(6000);
      chk({31'h0, scm_link_if_i.int_n}, 32'h1);
      wait (scm_link_if_i.int_n === 1'b0);
      wait (scm_link_if_i.rst_n === 1'b0);
      wt(4);
      chk({31'h0, scm_link_if_i.int_n}, 32'h1);
      $display("watchdog test done");
      close_out();
   end
endmodule // switch_contact_monitor_supervisor_test
